//--- core/spsf_pkg.sv
// ============================================================
// Status flag package
package spsf_pkg;

    // ============================================================
    // Field positions inside the status nibble
    localparam int unsigned FLAG_START_BIT  = 3;   // Start seen last
    localparam int unsigned FLAG_DIR_BIT    = 2;   // Direction, read is one
    localparam int unsigned FLAG_UPDATE_BIT = 1;   // Address reload needed
    localparam int unsigned FLAG_FULL_BIT   = 0;   // Data buffer full
    localparam int unsigned FLAG_W          = 4;   // Width of the nibble

    // ============================================================
    // Reset values
    localparam logic        START_RST  = 1'b0;
    localparam logic        DIR_RST    = 1'b0;
    localparam logic        UPDATE_RST = 1'b0;
    localparam logic        FULL_RST   = 1'b0;
    localparam logic        VALID_RST  = 1'b0;

    // ============================================================
    // Direction encoding
    localparam logic        DIR_READ   = 1'b1;
    localparam logic        DIR_WRITE  = 1'b0;

    // Default data width of the buffer
    localparam int unsigned DATA_W_DEF = 8;

    // Occupancy of the two-entry buffer
    typedef enum logic [1:0] {
        SPSF_EMPTY,
        SPSF_ONE,
        SPSF_TWO
    } spsf_fill_t;

endpackage

//--- core/spsf_status_flags.sv
`timescale 1ns/1ps
// ============================================================
// Status flags with a two-entry receive buffer
module spsf_status_flags
    import spsf_pkg::*;
#(
    parameter int unsigned DATA_W = DATA_W_DEF   // Byte width
) (
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              clkEn,
    // Configuration levels
    input  wire logic              portEnable,
    input  wire logic              i2cMode,
    input  wire logic              tenBitMode,
    // Bus condition pulses
    input  wire logic              startDetect,
    input  wire logic              stopDetect,
    input  wire logic              ackDetect,
    // Address comparator
    input  wire logic              addrMatch,
    input  wire logic              addrDirRead,
    input  wire logic              addrUpdateReq,
    input  wire logic              addrReloaded,
    // Receive stream from the shifter
    input  wire logic              rxValid,
    input  wire logic [DATA_W-1:0] rxData,
    output logic                   rxReady,
    // Receive stream to software
    output logic                   bufValid,
    output logic      [DATA_W-1:0] bufData,
    input  wire logic              bufReady,
    // Transmit strobes
    input  wire logic              txLoad,
    input  wire logic              txDone,
    // Status
    output logic      [FLAG_W-1:0] statusFlags,
    output logic                   dirValid
);

    // ============================================================
    // Buffer state
    logic              v0;          // Head entry holds a byte
    logic              v1;          // Second entry holds a byte
    logic [DATA_W-1:0] d0;          // Head byte, seen by software
    logic [DATA_W-1:0] d1;          // Second byte
    logic              next_v0;
    logic              next_v1;
    logic [DATA_W-1:0] next_d0;
    logic [DATA_W-1:0] next_d1;
    logic              push;        // Byte accepted from shifter
    logic              pop;         // Byte taken by software
    spsf_fill_t        fill;        // Occupancy, for visibility
    logic              spaceFree;   // Second slot free, drives ready
    logic              next_spaceFree;

    // ============================================================
    // Flag state
    logic startSeen;                // Start was the last condition
    logic lastDir;                  // Captured direction
    logic updateNeeded;             // Address must be reloaded
    logic txBusy;                   // Transmit byte still in flight
    logic bufFull;                  // Combined full flag
    logic dirOk;                    // Direction is meaningful
    logic next_startSeen;
    logic next_lastDir;
    logic next_updateNeeded;
    logic next_txBusy;
    logic next_bufFull;
    logic next_dirOk;

    // Accept only while the second slot is free
    assign push = rxValid && !v1;
    assign pop  = v0 && bufReady;

    // ============================================================
    // Buffer next state
    always_comb begin
        next_v0 = v0;
        next_v1 = v1;
        next_d0 = d0;
        next_d1 = d1;
        // Software takes the head, second moves up
        if (pop) begin
            next_v0 = v1;
            next_d0 = d1;
            next_v1 = 1'b0;
        end
        // Fill head first so a stall never drops a byte
        if (push) begin
            if (!next_v0) begin
                next_v0 = 1'b1;
                next_d0 = rxData;
            end else begin
                next_v1 = 1'b1;
                next_d1 = rxData;
            end
        end
        // Disabled port forgets buffered bytes
        if (!portEnable) begin
            next_v0 = VALID_RST;
            next_v1 = VALID_RST;
        end
        // Ready follows the second slot, one flop deep
        next_spaceFree = !next_v1;
    end

    // Buffer registers, frozen while enable is low
    always_ff @(posedge clk) begin
        if (rst) begin
            v0 <= VALID_RST;
            v1 <= VALID_RST;
            d0 <= '0;
            d1 <= '0;
            spaceFree <= !VALID_RST;
        end else if (clkEn) begin
            v0 <= next_v0;
            v1 <= next_v1;
            d0 <= next_d0;
            d1 <= next_d1;
            spaceFree <= next_spaceFree;
        end
    end

    // Occupancy decode for debug views
    always_comb begin
        case ({v1, v0})
            2'b01:   fill = SPSF_ONE;
            2'b11:   fill = SPSF_TWO;
            default: fill = SPSF_EMPTY;
        endcase
    end

    // ============================================================
    // Flag next state; no software write path exists
    always_comb begin
        next_startSeen    = startSeen;
        next_lastDir      = lastDir;
        next_updateNeeded = updateNeeded;
        next_txBusy       = txBusy;
        next_dirOk        = dirOk;
        // Stop clears, a same-cycle start wins as most recent
        if (stopDetect) begin
            next_startSeen = 1'b0;
        end
        if (i2cMode && startDetect) begin
            next_startSeen = 1'b1;
        end
        // Any bus condition ends the direction span
        if (startDetect || stopDetect || ackDetect) begin
            next_dirOk = 1'b0;
        end
        if (i2cMode && addrMatch) begin
            next_lastDir = addrDirRead ? DIR_READ : DIR_WRITE;
            next_dirOk   = 1'b1;
        end
        // Software reload clears, a new request wins
        if (addrReloaded) begin
            next_updateNeeded = 1'b0;
        end
        if (i2cMode && tenBitMode && addrUpdateReq) begin
            next_updateNeeded = 1'b1;
        end
        // Transmit occupancy, I2C only
        if (txDone) begin
            next_txBusy = 1'b0;
        end
        if (i2cMode && txLoad) begin
            next_txBusy = 1'b1;
        end
        // Disabled port clears all flags except the captured direction
        if (!portEnable) begin
            next_startSeen    = START_RST;
            next_updateNeeded = UPDATE_RST;
            next_txBusy       = FULL_RST;
            next_dirOk        = VALID_RST;
            next_lastDir      = lastDir;    // No capture while disabled
        end
        // Full while a received byte waits or a transmit runs
        next_bufFull = next_v0 || next_txBusy;
    end

    // Flag registers; bus events, software reload, port enable and buffer occupancy reach them
    always_ff @(posedge clk) begin
        if (rst) begin
            startSeen    <= START_RST;
            lastDir      <= DIR_RST;
            updateNeeded <= UPDATE_RST;
            txBusy       <= FULL_RST;
            bufFull      <= FULL_RST;
            dirOk        <= VALID_RST;
        end else if (clkEn) begin
            startSeen    <= next_startSeen;
            lastDir      <= next_lastDir;
            updateNeeded <= next_updateNeeded;
            txBusy       <= next_txBusy;
            bufFull      <= next_bufFull;
            dirOk        <= next_dirOk;
        end
    end

    // ============================================================
    // Outputs, all straight from flops
    always_comb begin
        statusFlags                  = '0;
        statusFlags[FLAG_START_BIT]  = startSeen;
        statusFlags[FLAG_DIR_BIT]    = lastDir;
        statusFlags[FLAG_UPDATE_BIT] = updateNeeded;
        statusFlags[FLAG_FULL_BIT]   = bufFull;
    end
    assign dirValid = dirOk;
    // Registered so the shifter sees a settled ready
    assign rxReady  = spaceFree;
    assign bufValid = v0;
    assign bufData  = d0;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    start_set_a: assert property (
        clkEn && portEnable && i2cMode && startDetect |=> statusFlags[FLAG_START_BIT])
        else $error("start flag not set");
    reset_clear_a: assert property (
        $fell(rst) |-> statusFlags == '0 && !dirValid)
        else $error("flags not zero after reset");
    start_clear_a: assert property (
        clkEn && (!portEnable || (stopDetect && !startDetect))
        |=> !statusFlags[FLAG_START_BIT])
        else $error("start flag not cleared");
    dir_capture_a: assert property (
        clkEn && portEnable && i2cMode && addrMatch
        |=> statusFlags[FLAG_DIR_BIT] == $past(addrDirRead) && dirValid)
        else $error("direction not captured");
    dir_span_a: assert property (
        clkEn && !addrMatch && (startDetect || stopDetect || ackDetect) |=> !dirValid)
        else $error("direction still marked valid");
    update_set_a: assert property (
        clkEn && portEnable && i2cMode && tenBitMode && addrUpdateReq
        |=> statusFlags[FLAG_UPDATE_BIT])
        else $error("address update flag not set");
    rx_full_a: assert property (
        bufValid |-> statusFlags[FLAG_FULL_BIT])
        else $error("full flag low with byte waiting");
    rx_empty_a: assert property (
        !bufValid && !txBusy |-> !statusFlags[FLAG_FULL_BIT])
        else $error("full flag high while empty");
    tx_hold_a: assert property (
        clkEn && portEnable && i2cMode && txLoad |=> statusFlags[FLAG_FULL_BIT])
        else $error("full flag low during transmit");
    flag_quiet_a: assert property (
        !clkEn |=> $stable(statusFlags) && $stable(dirValid))
        else $error("flags moved while frozen");
    no_loss_a: assert property (
        bufValid && !bufReady && portEnable |=> bufValid && $stable(bufData))
        else $error("buffered byte lost");

    fill_two_c: cover property (fill == SPSF_TWO && rxValid);
    start_stop_c: cover property (statusFlags[FLAG_START_BIT] ##[1:20] stopDetect);
    read_dir_c: cover property (addrMatch && addrDirRead && i2cMode && clkEn);
    tx_cycle_c: cover property (txBusy ##[1:20] !txBusy);

endmodule

//--- testbench/serial_port_status_flags_tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Testbench for the status flags
module serial_port_status_flags_tb_top;
    import spsf_pkg::*;
    // Event bits: start stop ack match read upd reloaded txLoad txDone
    localparam logic [8:0] EV_START = 9'h001;
    localparam logic [8:0] EV_STOP  = 9'h002;
    localparam logic [8:0] EV_ACK   = 9'h004;
    localparam logic [8:0] EV_MATCH = 9'h008;
    localparam logic [8:0] EV_READ  = 9'h010;
    localparam logic [8:0] EV_UPD   = 9'h020;
    localparam logic [8:0] EV_REL   = 9'h040;
    localparam logic [8:0] EV_TXL   = 9'h080;
    localparam logic [8:0] EV_TXD   = 9'h100;
    logic       clk, rst, clkEn, portEnable, i2cMode, tenBitMode, bufReady;
    logic       rxValid, rxReady, bufValid, dirValid;
    logic [7:0] rxData, bufData;
    logic [8:0] cond;
    logic [3:0] statusFlags;
    int         cycles, nMismatch, comparisons;

    spsf_bus_peer peer (.clk(clk), .rxReady(rxReady), .rxValid(rxValid),
        .rxData(rxData), .cond(cond));
    spsf_status_flags dut (.clk(clk), .rst(rst), .clkEn(clkEn), .portEnable(portEnable),
        .i2cMode(i2cMode), .tenBitMode(tenBitMode), .startDetect(cond[0]),
        .stopDetect(cond[1]), .ackDetect(cond[2]), .addrMatch(cond[3]),
        .addrDirRead(cond[4]), .addrUpdateReq(cond[5]), .addrReloaded(cond[6]),
        .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .bufValid(bufValid),
        .bufData(bufData), .bufReady(bufReady), .txLoad(cond[7]), .txDone(cond[8]),
        .statusFlags(statusFlags), .dirValid(dirValid));

    // Clock and hang guard; whole run is well under 2000 cycles
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            nMismatch = nMismatch + 1;
            endSim();
        end
    end

    // Verdict and stop
    task automatic endSim();
        if (nMismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Pulse events, then settle past the one-cycle answer
    task automatic ev(input logic [8:0] c);
        @(posedge clk);
        peer.pulse(c);
        @(posedge clk);
        #1;
    endtask

    // Check head byte, then take it
    task automatic pop(input logic [7:0] exp);
        @(posedge clk);
        #1;
        chk("bufData", exp, bufData);
        @(posedge clk);
        bufReady <= 1'b1;
        @(posedge clk);
        bufReady <= 1'b0;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        clk         = 1'b0;
        rst         = 1'b1;
        clkEn       = 1'b1;
        portEnable  = 1'b1;
        i2cMode     = 1'b1;
        tenBitMode  = 1'b1;
        bufReady    = 1'b0;
        cycles      = 0;
        nMismatch   = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("flags", 8'h00, statusFlags);
        chk("rxReady", 8'h01, rxReady);
        ev(EV_START);
        chk("start", 8'h01, statusFlags[FLAG_START_BIT]);
        ev(EV_STOP);
        chk("start", 8'h00, statusFlags[FLAG_START_BIT]);
        ev(EV_START | EV_STOP);
        chk("start", 8'h01, statusFlags[FLAG_START_BIT]);
        // Disable clears the start flag
        @(posedge clk);
        portEnable <= 1'b0;
        repeat (2) @(posedge clk);
        portEnable <= 1'b1;
        #1;
        chk("start", 8'h00, statusFlags[FLAG_START_BIT]);
        // Direction capture and validity span
        ev(EV_MATCH | EV_READ);
        chk("dir", 8'h01, statusFlags[FLAG_DIR_BIT]);
        chk("dirValid", 8'h01, dirValid);
        ev(EV_ACK);
        chk("dirValid", 8'h00, dirValid);
        ev(EV_MATCH);
        chk("dir", 8'h00, statusFlags[FLAG_DIR_BIT]);
        ev(EV_STOP);
        chk("dirValid", 8'h00, dirValid);
        // Ten-bit address reload request
        ev(EV_UPD);
        chk("update", 8'h01, statusFlags[FLAG_UPDATE_BIT]);
        ev(EV_REL);
        chk("update", 8'h00, statusFlags[FLAG_UPDATE_BIT]);
        @(posedge clk);
        tenBitMode <= 1'b0;
        ev(EV_UPD);
        chk("update", 8'h00, statusFlags[FLAG_UPDATE_BIT]);
        // SPI mode ignores start and transmit
        @(posedge clk);
        i2cMode <= 1'b0;
        ev(EV_START | EV_TXL);
        chk("flags", 8'h00, statusFlags);
        // Frozen clock enable drops events
        @(posedge clk);
        i2cMode <= 1'b1;
        clkEn <= 1'b0;
        ev(EV_START);
        chk("start", 8'h00, statusFlags[FLAG_START_BIT]);
        @(posedge clk);
        clkEn <= 1'b1;
        // Transmit occupancy
        ev(EV_TXL);
        chk("full", 8'h01, statusFlags[FLAG_FULL_BIT]);
        ev(EV_TXD);
        chk("full", 8'h00, statusFlags[FLAG_FULL_BIT]);
        // Receive: fill until refused, then drain in order
        @(posedge clk);
        peer.send(8'ha1);
        peer.send(8'hb2);
        fork
            begin
                peer.send(8'hc3);
                peer.idle();
            end
        join_none
        @(posedge clk);
        #1;
        chk("rxReady", 8'h00, rxReady);
        chk("full", 8'h01, statusFlags[FLAG_FULL_BIT]);
        pop(8'ha1);
        pop(8'hb2);
        pop(8'hc3);
        @(posedge clk);
        #1;
        chk("full", 8'h00, statusFlags[FLAG_FULL_BIT]);
        chk("bufValid", 8'h00, bufValid);
        // Reset in mid-run clears flags that were set
        ev(EV_START);
        ev(EV_MATCH | EV_READ);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("flags", 8'h00, statusFlags);
        chk("dirValid", 8'h00, dirValid);
        chk("rxReady", 8'h01, rxReady);
        endSim();
    end
endmodule

//--- testbench/spsf_bus_peer.sv
`timescale 1ns/1ps
// ============================================================
// Far-side peer: bus conditions and received bytes
module spsf_bus_peer (
    // Clock
    input  wire logic       clk,
    // Receive handshake
    input  wire logic       rxReady,
    output logic            rxValid,
    output logic      [7:0] rxData,
    // Event pulses, one bit each
    output logic      [8:0] cond
);
    // Idle at time zero
    initial begin
        rxValid = 1'b0;
        rxData  = 8'h00;
        cond    = 9'h000;
    end

    // One-cycle pulse of any event set
    task automatic pulse(input logic [8:0] c);
        cond <= c;
        @(posedge clk);
        cond <= 9'h000;
    endtask

    // Offer held until an edge that samples ready high; stays up for back-to-back offers
    task automatic send(input logic [7:0] b);
        logic taken;
        rxValid <= 1'b1;
        rxData  <= b;
        taken = 1'b0;
        while (!taken) begin
            // Ready is a flop, so its falling-edge value is what the next rise samples
            @(negedge clk);
            taken = (rxReady === 1'b1);
            @(posedge clk);
        end
    endtask

    // Drop the offer; inverted data never looks stale
    task automatic idle();
        rxValid <= 1'b0;
        rxData  <= ~rxData;
    endtask
endmodule
